// ===== shared/capture_pkg.sv
package capture_pkg;

   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned POS_W  = 32;
   localparam int unsigned CNT_W  = 16;

   // parameter addresses
   localparam logic [ADDR_W-1:0] OFS_DONE_FLAGS   = 16'h0A02;
   localparam logic [ADDR_W-1:0] OFS_EDGE_SELECT  = 16'h0A04;
   localparam logic [ADDR_W-1:0] OFS_RUN_CONTROL  = 16'h0A08;
   localparam logic [ADDR_W-1:0] OFS_CAPTURED_POS = 16'h0A0C;
   localparam logic [ADDR_W-1:0] OFS_EVENT_COUNT  = 16'h0A10;

   // field positions and codes
   localparam int unsigned EDGE_SEL_BIT   = 0;
   localparam int unsigned DONE_FIRST_BIT = 0;
   localparam logic [15:0] RUN_STOP       = 16'h0000;
   localparam logic [15:0] RUN_ONCE       = 16'h0001;
   localparam logic [15:0] RUN_CONTINUOUS = 16'h0002;
   localparam logic        EDGE_FALLING   = 1'h0;
   localparam logic        EDGE_RISING    = 1'h1;

   // reset values
   localparam logic              RST_EDGE_SELECT = 1'h0;
   localparam logic [POS_W-1:0]  RST_CAPTURED    = 32'h0000_0000;
   localparam logic [CNT_W-1:0]  RST_COUNT       = 16'h0000;
   localparam logic              RST_DONE        = 1'h0;
   localparam logic [DATA_W-1:0] RST_RDATA       = 32'h0000_0000;

   typedef enum logic [2:0]
   {
      CAP_IDLE       = 3'b001,
      CAP_ONCE       = 3'b010,
      CAP_CONTINUOUS = 3'b100
   } cap_state_t;

   typedef struct packed
   {
      logic              valid;
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } param_req_t;

   typedef struct packed
   {
      logic              ack;
      logic [DATA_W-1:0] rdata;
   } param_rsp_t;

endpackage : capture_pkg

// ===== hw/capture_edge_detect.sv
`timescale 1ns/10ps
`default_nettype none

module capture_edge_detect
   import capture_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic pin_in,
   input  wire logic rising_sel,
   output var  logic edge_seen
);

   logic meta_r;
   logic sync_r;
   logic prev_r;

   wire rise_w = sync_r & ~prev_r;
   wire fall_w = ~sync_r & prev_r;

   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         meta_r <= 1'h0;
         sync_r <= 1'h0;
         prev_r <= 1'h0;
      end
      else
      begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         prev_r <= sync_r;
      end
   end

   assign edge_seen = (rising_sel == EDGE_RISING) ? rise_w : fall_w;

endmodule : capture_edge_detect

`default_nettype wire

// ===== hw/position_capture_unit.sv
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - writing 0 to run control stops capture and stays idle
// - writing 1 to run control arms one single capture
// - writing 2 to run control arms capture on every qualifying edge
// - single mode disarms itself after the first latched position
// - continuous mode stays armed until stopped by software
// - edge select 0 captures on falling edge, 1 on rising edge
// - read-only 16-bit counter counts every latched capture
// - event counter clears whenever a start command arms the channel
// - capture latches the signed 32-bit drive position, read-only
// - position redefinition shifts the stored captured position accordingly
// - done flags bit 0 set once the first input has captured
module position_capture_unit
   import capture_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              first_capture_input,
   input  wire logic [POS_W-1:0]  drive_position,
   input  wire logic              position_redefine,
   input  wire logic [POS_W-1:0]  position_shift,
   input  wire param_req_t        param_req,
   output var  param_rsp_t        param_rsp
);

   cap_state_t        state_r;
   cap_state_t        state_nxt;
   logic              edge_sel_r;
   logic [POS_W-1:0]  captured_r;
   logic [POS_W-1:0]  captured_nxt;
   logic [CNT_W-1:0]  count_r;
   logic [CNT_W-1:0]  count_nxt;
   logic              done_r;
   logic              done_nxt;
   param_rsp_t        rsp_r;
   logic              edge_seen;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   function automatic logic [DATA_W-1:0] zext16(input logic [15:0] v);
      zext16 = {16'h0000, v};
   endfunction : zext16

   function automatic logic [15:0] run_code(input cap_state_t s);
      case (s)
         CAP_ONCE:       run_code = RUN_ONCE;
         CAP_CONTINUOUS: run_code = RUN_CONTINUOUS;
         default:        run_code = RUN_STOP;
      endcase
   endfunction : run_code

   capture_edge_detect u_edge
   (
      .clk        (clk),
      .reset      (reset),
      .pin_in     (first_capture_input),
      .rising_sel (edge_sel_r),
      .edge_seen  (edge_seen)
   );

   // write decode
   wire wr_w       = param_req.valid & param_req.write;
   wire rd_w       = param_req.valid & ~param_req.write;
   wire wr_edge_w  = wr_w & hit(param_req.addr, OFS_EDGE_SELECT);
   wire wr_run_w   = wr_w & hit(param_req.addr, OFS_RUN_CONTROL);
   wire [15:0] wval_w = param_req.wdata[15:0];
   // other run codes change nothing
   wire cmd_stop_w = wr_run_w & (wval_w == RUN_STOP);
   wire cmd_once_w = wr_run_w & (wval_w == RUN_ONCE);
   wire cmd_cont_w = wr_run_w & (wval_w == RUN_CONTINUOUS);
   wire cmd_start_w = cmd_once_w | cmd_cont_w;

   wire armed_w = (state_r == CAP_ONCE) | (state_r == CAP_CONTINUOUS);
   // stop write cancels a coinciding edge
   wire capture_w = armed_w & edge_seen & ~cmd_stop_w;
   // start clears count before a coinciding capture
   wire [CNT_W-1:0] count_base_w = cmd_start_w ? RST_COUNT : count_r;

   // capture channel state
   always_comb
   begin
      state_nxt = state_r;
      unique case (state_r)
         CAP_IDLE:
         begin
            state_nxt = CAP_IDLE;
         end
         CAP_ONCE:
         begin
            if (capture_w)
               state_nxt = CAP_IDLE;
         end
         CAP_CONTINUOUS:
         begin
            state_nxt = CAP_CONTINUOUS;
         end
      endcase
      if (cmd_stop_w)
         state_nxt = CAP_IDLE;
      if (cmd_once_w)
         state_nxt = CAP_ONCE;
      if (cmd_cont_w)
         state_nxt = CAP_CONTINUOUS;
   end

   // captured position and event count
   always_comb
   begin
      captured_nxt = captured_r;
      count_nxt    = count_r;
      done_nxt     = done_r;
      if (position_redefine)
         captured_nxt = captured_r + position_shift;
      if (cmd_start_w)
      begin
         count_nxt = RST_COUNT;
         done_nxt  = RST_DONE;
      end
      if (capture_w)
      begin
         captured_nxt = drive_position;
         count_nxt = count_base_w + 16'h0001;
         done_nxt = 1'h1;
      end
   end

   // read multiplexer
   logic [DATA_W-1:0] rdata_w;
   always_comb
   begin
      // unmapped addresses read zero
      rdata_w = RST_RDATA;
      if (hit(param_req.addr, OFS_DONE_FLAGS))
         rdata_w[DONE_FIRST_BIT] = done_r;
      else if (hit(param_req.addr, OFS_EDGE_SELECT))
         rdata_w[EDGE_SEL_BIT] = edge_sel_r;
      else if (hit(param_req.addr, OFS_RUN_CONTROL))
         rdata_w = zext16(run_code(state_r));
      else if (hit(param_req.addr, OFS_CAPTURED_POS))
         rdata_w = captured_r;
      else if (hit(param_req.addr, OFS_EVENT_COUNT))
         rdata_w = zext16(count_r);
   end

   // channel mode register
   always_ff @(posedge clk)
   begin
      if (reset)
         state_r <= CAP_IDLE;
      else
         state_r <= state_nxt;
   end

   always_ff @(posedge clk)
   begin
      if (reset)
         edge_sel_r <= RST_EDGE_SELECT;
      else if (wr_edge_w)
         edge_sel_r <= param_req.wdata[EDGE_SEL_BIT];
   end

   // capture result registers
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         captured_r <= RST_CAPTURED;
         count_r    <= RST_COUNT;
         done_r     <= RST_DONE;
      end
      else
      begin
         captured_r <= captured_nxt;
         count_r    <= count_nxt;
         done_r     <= done_nxt;
      end
   end

   // answer one cycle after each request
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         rsp_r.ack   <= 1'h0;
         rsp_r.rdata <= RST_RDATA;
      end
      else
      begin
         rsp_r.ack <= param_req.valid;
         if (rd_w)
            rsp_r.rdata <= rdata_w;
      end
   end

   // port driven straight from the answer register
   assign param_rsp = rsp_r;

endmodule : position_capture_unit

`default_nettype wire

// ===== test/capture_checker.sv
`timescale 1ns/10ps
`default_nettype none

module capture_checker
   import capture_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             first_capture_input,
   input  wire logic [POS_W-1:0] drive_position,
   input  wire logic             position_redefine,
   input  wire logic [POS_W-1:0] position_shift,
   input  wire param_req_t       param_req,
   input  wire param_rsp_t       param_rsp
);
   wire logic [DATA_W-1:0] rdat = param_rsp.rdata;
   wire logic              mapped = param_req.addr inside {OFS_DONE_FLAGS, OFS_EDGE_SELECT,
      OFS_RUN_CONTROL, OFS_CAPTURED_POS, OFS_EVENT_COUNT};

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   sequence rd_at(logic [ADDR_W-1:0] a);
      param_req.valid && !param_req.write && param_req.addr == a;
   endsequence

   ack_follows_a: assert property (param_req.valid |=> param_rsp.ack)
      else $error("request not answered");
   ack_only_a: assert property (!param_req.valid |=> !param_rsp.ack)
      else $error("answer without request");
   wr_keeps_data_a: assert property (param_req.valid && param_req.write |=> $stable(rdat))
      else $error("write changed read data");
   unmapped_zero_a: assert property (param_req.valid && !param_req.write && !mapped
      |=> rdat == 32'h0000_0000) else $error("unmapped read not zero");
   edge_field_a: assert property (rd_at(OFS_EDGE_SELECT) |=> rdat[31:1] == 0)
      else $error("edge select wider than one bit");
   done_field_a: assert property (rd_at(OFS_DONE_FLAGS) |=> rdat[31:1] == 0)
      else $error("done flags upper bits set");
   count_width_a: assert property (rd_at(OFS_EVENT_COUNT) |=> rdat[31:16] == 0)
      else $error("counter wider than 16 bits");
   run_mode_a: assert property (rd_at(OFS_RUN_CONTROL) |=> rdat <= 32'h2)
      else $error("run control out of range");
endmodule : capture_checker

`default_nettype wire

// ===== test/capture_source.sv
`timescale 1ns/10ps
`default_nettype none

module capture_source
   import capture_pkg::*;
(
   input  wire logic             clk,
   input  wire logic [POS_W-1:0] pos_set,
   input  wire logic             level_set,
   output var  logic [POS_W-1:0] drive_position,
   output var  logic             first_capture_input
);
   // position source and pin, moved only on clock edges
   always_ff @(posedge clk)
   begin
      drive_position      <= pos_set;
      first_capture_input <= level_set;
   end
endmodule : capture_source

`default_nettype wire

// ===== test/test_position_capture_unit.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
   $display("Error %0t: got %h exp %h", $time, g, e); end end

module test_position_capture_unit
   import capture_pkg::*;
;
   logic              clk = 0;
   logic              reset = 1;
   logic [POS_W-1:0]  pos_set = 0;
   logic              level_set = 0;
   logic              position_redefine = 0;
   logic [POS_W-1:0]  position_shift = 0;
   param_req_t        param_req = '0;
   param_rsp_t        param_rsp;
   logic [POS_W-1:0]  drive_position;
   logic              first_capture_input;
   logic [DATA_W-1:0] rd;
   int                errors = 0;
   int                check_count = 0;

   capture_source src (.clk(clk), .pos_set(pos_set), .level_set(level_set),
      .drive_position(drive_position), .first_capture_input(first_capture_input));
   position_capture_unit dut (.clk(clk), .reset(reset),
      .first_capture_input(first_capture_input), .drive_position(drive_position),
      .position_redefine(position_redefine), .position_shift(position_shift),
      .param_req(param_req), .param_rsp(param_rsp));

   initial forever #50 clk = ~clk;

   task automatic give_verdict;
      $display("errors %0d checks %0d", errors, check_count);
      if (errors == 0 && check_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      @(posedge clk) param_req <= '{1'b1, w, a, d};
      @(posedge clk) param_req.valid <= 1'b0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (param_rsp.ack !== 1'b1 && n < 4);
      if (param_rsp.ack !== 1'b1)
      begin
         errors++;
         $display("Error %0t: no answer from unit", $time);
         give_verdict();
      end
      rd = param_rsp.rdata;
   endtask : acc

   task automatic exp_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      acc(1'b0, a, '0);
      `CHK(rd, e)
   endtask : exp_rd

   task automatic pin(input logic lvl, input logic [POS_W-1:0] p);
      @(posedge clk);
      pos_set   <= p;
      level_set <= lvl;
      repeat (6) @(posedge clk);
   endtask : pin

   task automatic t_defaults;
      exp_rd(OFS_EDGE_SELECT, 32'h0);
      exp_rd(OFS_RUN_CONTROL, 32'h0);
      exp_rd(OFS_DONE_FLAGS, 32'h0);
      exp_rd(OFS_EVENT_COUNT, 32'h0);
      exp_rd(16'h0A06, 32'h0);
      acc(1'b1, OFS_CAPTURED_POS, 32'h5);
      exp_rd(OFS_CAPTURED_POS, 32'h0);
   endtask : t_defaults

   task automatic t_once;
      pin(1'b1, 32'h0);
      acc(1'b1, OFS_RUN_CONTROL, 32'h1);
      pin(1'b0, 32'h1234_5678);
      exp_rd(OFS_CAPTURED_POS, 32'h1234_5678);
      exp_rd(OFS_EVENT_COUNT, 32'h1);
      exp_rd(OFS_DONE_FLAGS, 32'h1);
      exp_rd(OFS_RUN_CONTROL, 32'h0);
      pin(1'b1, 32'h0);
      pin(1'b0, 32'h0000_0BAD);
      exp_rd(OFS_EVENT_COUNT, 32'h1);
      exp_rd(OFS_CAPTURED_POS, 32'h1234_5678);
   endtask : t_once

   task automatic t_continuous;
      acc(1'b1, OFS_EDGE_SELECT, 32'h1);
      acc(1'b1, OFS_RUN_CONTROL, 32'h2);
      pin(1'b1, 32'h8000_0001);
      exp_rd(OFS_EVENT_COUNT, 32'h1);
      pin(1'b0, 32'h0);
      exp_rd(OFS_EVENT_COUNT, 32'h1);
      pin(1'b1, 32'hFFFF_FFF0);
      exp_rd(OFS_EVENT_COUNT, 32'h2);
      exp_rd(OFS_CAPTURED_POS, 32'hFFFF_FFF0);
      acc(1'b1, OFS_RUN_CONTROL, 32'h3);
      exp_rd(OFS_RUN_CONTROL, 32'h2);
   endtask : t_continuous

   task automatic t_stop;
      acc(1'b1, OFS_RUN_CONTROL, 32'h0);
      pin(1'b0, 32'h0);
      pin(1'b1, 32'h42);
      exp_rd(OFS_EVENT_COUNT, 32'h2);
      @(posedge clk);
      position_redefine <= 1'b1;
      position_shift    <= 32'h20;
      @(posedge clk) position_redefine <= 1'b0;
      exp_rd(OFS_CAPTURED_POS, 32'h10);
      acc(1'b1, OFS_RUN_CONTROL, 32'h1);
      exp_rd(OFS_EVENT_COUNT, 32'h0);
      pin(1'b0, 32'h0);
      pin(1'b1, 32'h7);
      exp_rd(OFS_CAPTURED_POS, 32'h7);
   endtask : t_stop

   initial
   begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      t_defaults();
      t_once();
      t_continuous();
      t_stop();
      give_verdict();
   end
endmodule : test_position_capture_unit

bind position_capture_unit capture_checker chk (.clk(clk), .reset(reset),
   .first_capture_input(first_capture_input), .drive_position(drive_position),
   .position_redefine(position_redefine), .position_shift(position_shift),
   .param_req(param_req), .param_rsp(param_rsp));

`default_nettype wire
